/* rtl/ea_unit.sv */
// effective address and operand generation unit
`include "ea_unit_cfg.svh"
`default_nettype none

// What this block does
// - register direct takes operand from selected 8-bit half or 16-bit register
// - word operands only for word move/add/sub/compare, address add/sub, multiply, divide, push, pop
// - register indirect uses the 16-bit register as operand address
// - displacement mode address_add_small second-word displacement to register; moves only
// - post-increment addresses with register then address_add_small 1 byte or 2 word
// - pre-decrement subtracts 1 or 2 first, uses and keeps result
// - short absolute forces upper address byte to all ones
// - short absolute for byte move and bit ops; long for moves and jumps
// - immediate is byte 2, or bytes 3-4 for word moves only
// - address add/sub imply 1 or 2; bit ops carry 3-bit bit number
// - relative branches sign-extend byte 2 displacement and add to PC
// - memory indirect zero-extends byte 2 and fetches target word there
// - odd branch target or word-move address has its LSB cleared
// - arithmetic uses register direct; listed byte ops may also use immediate
// - byte moves take all modes but PC relative and memory indirect; word moves also not short absolute
// - bit ops use register direct, indirect or short absolute with 3-bit bit number
// - set, clear, invert, test may take bit position from a register
// - push is pre-decrement word store, pop post-increment word load on stack
// - register seven is the stack pointer
module ea_unit
  import ea_unit_pkg::*;
(
  input wire logic mclk, // core clock
  input wire logic rst, // synchronous reset, high
  input wire ea_unit_pkg::ea_req_t req, // decoded instruction fields
  input wire logic [15:0] pc, // program counter
  input wire logic reg_we, // external register write
  input wire logic [2:0] reg_wsel, // register written
  input wire logic [15:0] reg_wdata, // write data
  output ea_unit_pkg::ea_res_t res, // registered result
  output logic [15:0] stack_ptr // register seven
);
  import ea_unit_pkg::*;

  logic [15:0] gregs_q [8];
  ea_res_t res_q;
  ea_res_t res_d;
  logic upd_en_d;
  logic [15:0] upd_val_d;
  logic [2:0] sel_d;
  logic [15:0] base;
  logic word_op;

  // wrapping 16-bit add
  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0];
  endfunction

  function automatic logic [15:0] even(input logic [15:0] a);
    return {a[15:1], 1'b0};
  endfunction

  always_comb
  begin
    sel_d = (req.group == GRP_PUSH || req.group == GRP_POP) ? `EA_STACK_REG : req.reg_sel;
    base = gregs_q[sel_d];
    word_op = req.group inside {GRP_WORD_MOVE, GRP_WORD_ARITH, GRP_ADDR_ADD_SUB, GRP_MUL_DIV,
      GRP_PUSH, GRP_POP};
  end

  always_comb
  begin
    res_d = '0;
    upd_en_d = 1'b0;
    upd_val_d = base;
    res_d.valid = req.valid;
    res_d.is_word = word_op;
    res_d.bit_num = req.bit_imm;
    case (req.mode)
      MODE_REG_DIRECT:
      begin
        res_d.operand_valid = 1'b1;
        if (word_op)
          res_d.operand = base;
        else
          res_d.operand = {8'h00, req.reg_low_half ? base[7:0] : base[15:8]};
        if (req.group == GRP_BIT_REGPOS)
          res_d.bit_num = res_d.operand[2:0];
        res_d.illegal = req.group inside {GRP_BRANCH, GRP_JUMP, GRP_PUSH, GRP_POP};
      end
      MODE_REG_INDIRECT:
      begin
        res_d.mem_access = 1'b1;
        res_d.addr = base;
        res_d.illegal = !(req.group inside {GRP_BYTE_MOVE, GRP_WORD_MOVE, GRP_BIT_MANIP,
          GRP_BIT_REGPOS, GRP_JUMP});
      end
      MODE_DISP16:
      begin
        res_d.mem_access = 1'b1;
        res_d.addr = add16(base, req.word2);
        res_d.illegal = !(req.group inside {GRP_BYTE_MOVE, GRP_WORD_MOVE});
      end
      MODE_POST_INC:
      begin
        res_d.mem_access = 1'b1;
        res_d.addr = base;
        upd_en_d = 1'b1;
        upd_val_d = add16(base, word_op ? `EA_STEP_WORD : `EA_STEP_BYTE);
        res_d.illegal = !(req.group inside {GRP_BYTE_MOVE, GRP_WORD_MOVE, GRP_POP});
      end
      MODE_PRE_DEC:
      begin
        res_d.mem_access = 1'b1;
        upd_en_d = 1'b1;
        upd_val_d = add16(base, word_op ? ~`EA_STEP_WORD + 16'h0001 : 16'hffff);
        res_d.addr = upd_val_d;
        res_d.illegal = !(req.group inside {GRP_BYTE_MOVE, GRP_WORD_MOVE, GRP_PUSH});
      end
      MODE_ABS8:
      begin
        res_d.mem_access = 1'b1;
        res_d.addr = {`EA_SHORT_ABS_HI, req.byte2};
        res_d.illegal = !(req.group inside {GRP_BYTE_MOVE, GRP_BIT_MANIP,
          GRP_BIT_REGPOS});
      end
      MODE_ABS16:
      begin
        res_d.mem_access = 1'b1;
        res_d.addr = req.word2;
        res_d.illegal = !(req.group inside {GRP_BYTE_MOVE, GRP_WORD_MOVE, GRP_JUMP});
      end
      MODE_IMM:
      begin
        res_d.operand_valid = 1'b1;
        if (req.group == GRP_ADDR_ADD_SUB)
          res_d.operand = req.step_two ? `EA_STEP_WORD : `EA_STEP_BYTE;
        else if (req.group == GRP_WORD_MOVE)
          res_d.operand = req.word2;
        else
          res_d.operand = {8'h00, req.byte2};
        res_d.illegal = !(req.group inside {GRP_BYTE_MOVE, GRP_WORD_MOVE, GRP_ARITH_IMM,
          GRP_ADDR_ADD_SUB});
      end
      MODE_PC_REL:
      begin
        res_d.addr = even(add16(pc, {{8{req.byte2[7]}}, req.byte2}));
        res_d.illegal = (req.group != GRP_BRANCH);
      end
      MODE_MEM_INDIRECT:
      begin
        res_d.mem_access = 1'b1;
        res_d.fetch_target = 1'b1;
        res_d.is_word = 1'b1;
        res_d.addr = even({`EA_INDIRECT_HI, req.byte2});
        res_d.illegal = (req.group != GRP_JUMP);
      end
      default:
        res_d.illegal = 1'b1;
    endcase
    if (res_d.is_word && res_d.mem_access)
      res_d.addr = even(res_d.addr);
    // a jump target is an instruction address, so it is word aligned in every mode
    if (req.group == GRP_JUMP)
      res_d.addr = even(res_d.addr);
    // a refused request never steps a pointer
    if (!req.valid || res_d.illegal)
      upd_en_d = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      res_q <= '0;
    else
      res_q <= res_d;
  end

  // writeback of stepped pointer wins over external write to same register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 8; i++)
        gregs_q[i] <= `EA_REG_RESET;
    end
    else
    begin
      if (reg_we)
        gregs_q[reg_wsel] <= reg_wdata;
      if (req.valid && upd_en_d)
        gregs_q[sel_d] <= upd_val_d;
    end
  end

  assign res = res_q;
  assign stack_ptr = gregs_q[`EA_STACK_REG];

  sequence s_pre_req;
    req.valid && req.mode == MODE_PRE_DEC && !res_d.illegal;
  endsequence

  sequence s_word_post_req;
    req.valid && req.mode == MODE_POST_INC && !res_d.illegal && word_op;
  endsequence

  sequence s_refused_req;
    req.valid && res_d.illegal;
  endsequence

  sequence s_post_req;
    req.valid && req.mode == MODE_POST_INC && !res_d.illegal && !word_op;
  endsequence

  AST_SHORT_ABS_HIGH: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode == MODE_ABS8) |=> res.addr[15:8] == 8'hff)
    else $error("short absolute high byte wrong");
  AST_INDIRECT_LOW_PAGE: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode == MODE_MEM_INDIRECT) |=> res.addr[15:8] == 8'h00 && res.fetch_target)
    else $error("memory indirect address out of page");
  AST_WORD_EVEN: assert property (@(posedge mclk) disable iff (rst)
    (res.valid && res.is_word && res.mem_access) |-> !res.addr[0])
    else $error("odd word address");
  AST_POST_INC_BYTE: assert property (@(posedge mclk) disable iff (rst)
    s_post_req ##0 !reg_we |=>
    gregs_q[$past(sel_d)] == $past(base) + 16'h0001)
    else $error("post increment step wrong");
  AST_PRE_DEC_ADDR: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode == MODE_PRE_DEC && word_op && !res_d.illegal) |=>
    res.addr == $past(base) - 16'h0002)
    else $error("pre decrement address wrong");
  AST_PC_REL_TARGET: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode == MODE_PC_REL) |=>
    res.addr == (($past(pc) + {{8{$past(req.byte2[7])}}, $past(req.byte2)}) & 16'hfffe))
    else $error("branch target wrong");
  AST_DISP_MOVE_ONLY: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode == MODE_DISP16 && !(req.group inside {GRP_BYTE_MOVE,
    GRP_WORD_MOVE})) |=> res.illegal)
    else $error("displacement accepted outside moves");
  AST_IMPLIED_STEP: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode == MODE_IMM && req.group == GRP_ADDR_ADD_SUB) |=>
    res.operand == ($past(req.step_two) ? 16'h0002 : 16'h0001))
    else $error("implied immediate wrong");
  AST_RELATIVE_ILLEGAL_MOVE: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.group == GRP_BYTE_MOVE && req.mode inside {MODE_PC_REL,
    MODE_MEM_INDIRECT}) |=> res.illegal)
    else $error("move accepted relative mode");

  // mode legality, stepping and operand shape
  AST_BYTE_UPPER_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode == MODE_REG_DIRECT && !word_op) |=>
    res.operand[15:8] == 8'h00)
    else $error("byte operand upper half not zero");
  AST_BYTE_SIZE: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode != MODE_MEM_INDIRECT && req.group inside {GRP_BYTE_MOVE,
    GRP_ARITH_IMM, GRP_ARITH_REG, GRP_BIT_MANIP}) |=> !res.is_word)
    else $error("byte instruction flagged as word");
  AST_INDIRECT_ADDR: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode == MODE_REG_INDIRECT && !word_op && req.group != GRP_JUMP) |=>
    res.addr == $past(base))
    else $error("register indirect address wrong");
  AST_POST_INC_WORD: assert property (@(posedge mclk) disable iff (rst)
    s_word_post_req |=>
    gregs_q[$past(sel_d)] == $past(base) + 16'h0002)
    else $error("post increment word step wrong");
  AST_PRE_DEC_KEEP: assert property (@(posedge mclk) disable iff (rst)
    s_pre_req |=>
    gregs_q[$past(sel_d)] == $past(base) - ($past(word_op) ? 16'h0002 : 16'h0001))
    else $error("pre decrement value not kept");
  AST_LONG_ABS_GROUPS: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode == MODE_ABS16 && req.group inside {GRP_BIT_MANIP,
    GRP_ARITH_REG}) |=> res.illegal)
    else $error("long absolute accepted outside moves and jumps");
  AST_IMM_BYTE: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode == MODE_IMM && req.group inside {GRP_BYTE_MOVE,
    GRP_ARITH_IMM}) |=> res.operand == {8'h00, $past(req.byte2)})
    else $error("byte immediate wrong");
  AST_ARITH_NO_IMM: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.mode == MODE_IMM && req.group inside {GRP_ARITH_REG, GRP_WORD_ARITH,
    GRP_MUL_DIV}) |=> res.illegal)
    else $error("immediate accepted by register-only arithmetic");
  AST_BIT_MODES: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.group == GRP_BIT_MANIP && req.mode inside {MODE_DISP16, MODE_POST_INC,
    MODE_PRE_DEC, MODE_IMM}) |=> res.illegal)
    else $error("bit operand mode accepted");
  AST_REG_BIT_POS: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.group == GRP_BIT_REGPOS && req.mode == MODE_REG_DIRECT) |=>
    res.bit_num == ($past(req.reg_low_half) ? $past(base[2:0]) : $past(base[10:8])))
    else $error("bit position from register wrong");
  AST_PUSH_STACK: assert property (@(posedge mclk) disable iff (rst)
    (req.valid && req.group == GRP_PUSH && req.mode == MODE_PRE_DEC) |=>
    res.is_word && res.addr == $past(stack_ptr) - 16'h0002)
    else $error("push not a word pre decrement of the stack pointer");
  AST_REFUSED_KEEPS_REG: assert property (@(posedge mclk) disable iff (rst)
    s_refused_req ##0 !reg_we |=>
    gregs_q[$past(sel_d)] == $past(base))
    else $error("refused request changed a register");
  AST_STEP_WRAPS: assert property (@(posedge mclk) disable iff (rst)
    s_post_req ##0 base == 16'hffff |=>
    gregs_q[$past(sel_d)] == 16'h0000)
    else $error("post increment did not wrap");
endmodule // ea_unit
`default_nettype wire

/* rtl/ea_unit_cfg.svh */
// constants for the effective address unit
`ifndef EA_UNIT_CFG_SVH
`define EA_UNIT_CFG_SVH
`define EA_SHORT_ABS_HI 8'hff
`define EA_INDIRECT_HI 8'h00
`define EA_STEP_BYTE 16'h0001
`define EA_STEP_WORD 16'h0002
`define EA_STACK_REG 3'h7
`define EA_REG_RESET 16'h0000
`endif

/* rtl/ea_unit_pkg.sv */
// types for the effective address unit
`default_nettype none
package ea_unit_pkg;
  typedef enum logic [3:0] {
    MODE_REG_DIRECT,
    MODE_REG_INDIRECT,
    MODE_DISP16,
    MODE_POST_INC,
    MODE_PRE_DEC,
    MODE_ABS8,
    MODE_ABS16,
    MODE_IMM,
    MODE_PC_REL,
    MODE_MEM_INDIRECT
  } ea_mode_t;

  typedef enum logic [3:0] {
    GRP_BYTE_MOVE,
    GRP_WORD_MOVE,
    GRP_WORD_ARITH,
    GRP_ADDR_ADD_SUB,
    GRP_MUL_DIV,
    GRP_ARITH_IMM,
    GRP_ARITH_REG,
    GRP_BIT_MANIP,
    GRP_BIT_REGPOS,
    GRP_BRANCH,
    GRP_JUMP,
    GRP_PUSH,
    GRP_POP
  } op_group_t;

  typedef struct packed {
    logic valid;
    op_group_t group;
    ea_mode_t mode;
    logic [2:0] reg_sel;
    logic reg_low_half;
    logic step_two;
    logic [7:0] byte2;
    logic [15:0] word2;
    logic [2:0] bit_imm;
  } ea_req_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic is_word;
    logic mem_access;
    logic [15:0] addr;
    logic [15:0] operand;
    logic operand_valid;
    logic fetch_target;
    logic [2:0] bit_num;
  } ea_res_t;
endpackage
`default_nettype wire

/* test/fetch_model.sv */
// program counter source standing in for the fetch sequencer
`default_nettype none
module fetch_model
(
  input wire logic mclk, // core clock
  input wire logic rst, // synchronous reset, high
  input wire logic jump, // load a new fetch address
  input wire logic [15:0] jump_to, // new fetch address
  output logic [15:0] pc // program counter toward the unit
);
  timeunit 1ns;
  timeprecision 1ns;
  // fetches are word wide, so the counter never holds an odd value
  always_ff @(posedge mclk)
  begin
    if (rst)
      pc <= 16'h0000;
    else if (jump)
      pc <= {jump_to[15:1], 1'b0};
  end
endmodule // fetch_model
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the effective address unit
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ea_unit_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  ea_req_t req = '0;
  logic reg_we = 1'b0;
  logic [2:0] reg_wsel = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic jump = 1'b0;
  logic [15:0] jump_to = 16'h0000;
  logic [15:0] pc;
  ea_res_t res;
  logic [15:0] stack_ptr;
  int n_errors = 0;
  int checked = 0;
  always #50 mclk = ~mclk;
  fetch_model pcm (.mclk(mclk), .rst(rst), .jump(jump), .jump_to(jump_to), .pc(pc));
  ea_unit dut (.mclk(mclk), .rst(rst), .req(req), .pc(pc), .reg_we(reg_we),
    .reg_wsel(reg_wsel), .reg_wdata(reg_wdata), .res(res), .stack_ptr(stack_ptr));
  task automatic c16(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic ea_req_t mk(op_group_t g, ea_mode_t md, logic [2:0] r, logic [7:0] b2,
    logic [15:0] w2);
    mk = '0;
    mk.valid = 1'b1;
    mk.group = g;
    mk.mode = md;
    mk.reg_sel = r;
    mk.reg_low_half = 1'b1;
    mk.byte2 = b2;
    mk.word2 = w2;
  endfunction
  task automatic run(input ea_req_t r);
    @(posedge mclk);
    req <= r;
    @(posedge mclk);
    req <= '0;
    #1;
  endtask
  task automatic wr(input logic [2:0] s, input logic [15:0] v);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_wsel <= s;
    reg_wdata <= v;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask
  task automatic ad(input ea_req_t r, input logic [15:0] a, input string m);
    run(r);
    c16(res.addr, a, m);
  endtask
  task automatic bad(input ea_req_t r, input string m);
    run(r);
    c16({15'h0, res.illegal}, 16'h0001, m);
  endtask
  task automatic t_direct;
    ea_req_t r;
    wr(3'h2, 16'h12a5);
    run(mk(GRP_BYTE_MOVE, MODE_REG_DIRECT, 3'h2, 8'h00, 16'h0000));
    c16(res.operand, 16'h00a5, "low half");
    c16({15'h0, res.is_word}, 16'h0000, "byte size");
    c16({14'h0, res.valid, res.operand_valid}, 16'h0003, "operand valid");
    r = mk(GRP_BYTE_MOVE, MODE_REG_DIRECT, 3'h2, 8'h00, 16'h0000);
    r.reg_low_half = 1'b0;
    run(r);
    c16(res.operand, 16'h0012, "high half");
    run(mk(GRP_MUL_DIV, MODE_REG_DIRECT, 3'h2, 8'h00, 16'h0000));
    c16({15'h0, res.is_word}, 16'h0001, "word size");
    run(mk(GRP_WORD_ARITH, MODE_REG_DIRECT, 3'h2, 8'h00, 16'h0000));
    c16(res.operand, 16'h12a5, "word operand");
    run(mk(GRP_ARITH_IMM, MODE_IMM, 3'h0, 8'h3c, 16'h0000));
    c16(res.operand, 16'h003c, "arith imm");
    bad(mk(GRP_ARITH_REG, MODE_IMM, 3'h0, 8'h3c, 16'h0000), "arith reg imm");
    r = mk(GRP_ADDR_ADD_SUB, MODE_IMM, 3'h0, 8'h00, 16'h0000);
    r.step_two = 1'b1;
    run(r);
    c16(res.operand, 16'h0002, "address_add_small two");
    r.step_two = 1'b0;
    run(r);
    c16(res.operand, 16'h0001, "address_add_small one");
    $display("done direct");
  endtask
  task automatic t_addr;
    wr(3'h3, 16'hfff0);
    ad(mk(GRP_BYTE_MOVE, MODE_REG_INDIRECT, 3'h3, 8'h00, 16'h0000), 16'hfff0, "ind");
    c16({15'h0, res.mem_access}, 16'h0001, "ind access");
    ad(mk(GRP_WORD_MOVE, MODE_DISP16, 3'h3, 8'h00, 16'h0020), 16'h0010, "disp");
    bad(mk(GRP_ARITH_REG, MODE_DISP16, 3'h3, 8'h00, 16'h0020), "disp arith");
    wr(3'h4, 16'hffff);
    ad(mk(GRP_BYTE_MOVE, MODE_POST_INC, 3'h4, 8'h00, 16'h0000), 16'hffff, "inc b");
    ad(mk(GRP_BYTE_MOVE, MODE_REG_INDIRECT, 3'h4, 8'h00, 16'h0000), 16'h0000, "wrap");
    wr(3'h5, 16'h1000);
    ad(mk(GRP_WORD_MOVE, MODE_PRE_DEC, 3'h5, 8'h00, 16'h0000), 16'h0ffe, "dec w");
    ad(mk(GRP_WORD_MOVE, MODE_POST_INC, 3'h5, 8'h00, 16'h0000), 16'h0ffe, "inc w");
    ad(mk(GRP_BYTE_MOVE, MODE_REG_INDIRECT, 3'h5, 8'h00, 16'h0000), 16'h1000, "kept");
    $display("done addr");
  endtask
  task automatic t_abs_imm;
    ea_req_t r;
    ad(mk(GRP_BYTE_MOVE, MODE_ABS8, 3'h0, 8'h34, 16'h0000), 16'hff34, "abs8");
    r = mk(GRP_BIT_MANIP, MODE_ABS8, 3'h0, 8'h34, 16'h0000);
    r.bit_imm = 3'h5;
    ad(r, 16'hff34, "bit abs8");
    c16({13'h0, res.bit_num}, 16'h0005, "bit imm");
    bad(mk(GRP_WORD_MOVE, MODE_ABS8, 3'h0, 8'h34, 16'h0000), "abs8 word");
    bad(mk(GRP_BIT_MANIP, MODE_ABS16, 3'h0, 8'h00, 16'h1234), "bit abs16");
    bad(mk(GRP_BIT_MANIP, MODE_DISP16, 3'h3, 8'h00, 16'h0000), "bit disp");
    ad(mk(GRP_JUMP, MODE_ABS16, 3'h0, 8'h00, 16'h1235), 16'h1234, "jump abs16");
    ad(mk(GRP_WORD_MOVE, MODE_ABS16, 3'h0, 8'h00, 16'h2001), 16'h2000, "odd word");
    run(mk(GRP_WORD_MOVE, MODE_IMM, 3'h0, 8'h00, 16'hbeef));
    c16(res.operand, 16'hbeef, "imm16");
    run(mk(GRP_BYTE_MOVE, MODE_IMM, 3'h0, 8'h7a, 16'hbeef));
    c16(res.operand, 16'h007a, "imm8");
    wr(3'h6, 16'h000b);
    run(mk(GRP_BIT_REGPOS, MODE_REG_DIRECT, 3'h6, 8'h00, 16'h0000));
    c16({13'h0, res.bit_num}, 16'h0003, "bit reg");
    $display("done abs_imm");
  endtask
  task automatic t_branch;
    @(posedge mclk);
    jump <= 1'b1;
    jump_to <= 16'h0100;
    @(posedge mclk);
    jump <= 1'b0;
    ad(mk(GRP_BRANCH, MODE_PC_REL, 3'h0, 8'hfe, 16'h0000), 16'h00fe, "rel back");
    ad(mk(GRP_BRANCH, MODE_PC_REL, 3'h0, 8'h80, 16'h0000), 16'h0080, "rel far");
    ad(mk(GRP_JUMP, MODE_MEM_INDIRECT, 3'h0, 8'h40, 16'h0000), 16'h0040, "mem ind");
    c16({15'h0, res.fetch_target}, 16'h0001, "fetch");
    wr(3'h1, 16'h1235);
    ad(mk(GRP_JUMP, MODE_REG_INDIRECT, 3'h1, 8'h00, 16'h0000), 16'h1234, "jump odd");
    bad(mk(GRP_BYTE_MOVE, MODE_PC_REL, 3'h0, 8'h02, 16'h0000), "move rel");
    bad(mk(GRP_WORD_MOVE, MODE_MEM_INDIRECT, 3'h0, 8'h40, 16'h0000), "move mind");
    $display("done branch");
  endtask
  task automatic t_stack;
    wr(3'h7, 16'h0200);
    #1;
    c16(stack_ptr, 16'h0200, "sp is r7");
    ad(mk(GRP_PUSH, MODE_PRE_DEC, 3'h2, 8'h00, 16'h0000), 16'h01fe, "push");
    c16(stack_ptr, 16'h01fe, "push sp");
    ad(mk(GRP_POP, MODE_POST_INC, 3'h2, 8'h00, 16'h0000), 16'h01fe, "pop");
    c16(stack_ptr, 16'h0200, "pop sp");
    bad(mk(GRP_ARITH_REG, MODE_PRE_DEC, 3'h7, 8'h00, 16'h0000), "arith dec");
    c16(stack_ptr, 16'h0200, "no update");
    $display("done stack");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_direct();
    t_addr();
    t_abs_imm();
    t_branch();
    t_stack();
    wrap_up();
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
